/* File: common/adcpc_pkg.sv */
/*
  adcpc_pkg: constants and carrier types for the converter port
  configuration and conversion control block.
  assumes: used by rtl/adcpc_top.sv and the testbench, never imported.
*/
package adcpc_pkg;
  // ----------------------------------------------------------------
  // register map (plain port, word index)
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_CTRL0 = 3'h0;
  localparam logic [2:0] ADDR_CTRL1 = 3'h1;
  localparam logic [2:0] ADDR_RES_HI = 3'h2;
  localparam logic [2:0] ADDR_RES_LO = 3'h3;
  localparam logic [2:0] ADDR_FLAG = 3'h4;
  localparam logic [2:0] ADDR_PORT_IN = 3'h5;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL0_ON = 0;
  localparam int CTRL0_START = 2;
  localparam int CTRL0_CH_LO = 3;
  localparam int CTRL0_RC = 6;
  localparam int CTRL1_JUSTIFY = 7;
  localparam logic [7:0] CTRL1_MASK = 8'h8F;
  localparam logic [7:0] CTRL0_MASK = 8'h7D;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int OSC_PER_INSTR = 4;   // one instruction = 4 osc periods
  localparam int CONV_TAD = 12;       // converter clocks per conversion
  localparam int TGO_HALF_OSC = 1;    // start delay in osc ticks
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] analog;   // 1 = pin feeds the input multiplexer
    logic vref_pos_ext;   // port_a_bit3 is the positive reference
    logic vref_neg_ext;   // port_a_bit2 is the negative reference
  } adcpc_pincfg_t;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } adcpc_bus_t;
endpackage

/* File: rtl/adcpc_top.sv */
/*
  adcpc_top: port configuration decode, conversion sequencing and result
  registers of a ten-bit converter.
  assumes: bus signals synchronous to i_clk_sys; i_osc_tick pulses one
  cycle per oscillator period; i_tad_tick one cycle per converter clock;
  the analog front end returns i_sample as the converted value.
*/
// Contract
// - the four-bit port config code selects analog or digital per pin.
// - reference codes take port_a_bit3 as positive, port_a_bit2 negative.
// - the ten-bit result is loaded into the high/low register pair.
// - at completion the start bit clears and the done flag sets together.
// - the result is readable on the clock cycle after completion.
// - converter clock starts one osc period after Q4, RC adds one instruction cycle.
// - one instruction cycle is four oscillator periods.
// - justify set gives right justification, clear gives left.
`timescale 1ns/10ps
module adcpc_top #(
  parameter int CONV_CLKS = adcpc_pkg::CONV_TAD
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_osc_tick,
  input wire logic i_tad_tick,
  input wire logic [7:0] i_pin_level,
  input wire logic [9:0] i_sample,
  output logic [7:0] o_rdata,
  output logic [7:0] o_analog_sel,
  output logic [2:0] o_mux_ch,
  output logic o_vref_pos_ext,
  output logic o_vref_neg_ext,
  output logic o_sampling,
  output logic o_done_flag,
  output logic o_instr_q4
);
  if (CONV_CLKS < 1 || CONV_CLKS > 15) begin : g_bad_conv_clks
    $error("CONV_CLKS out of range");
  end

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_WAIT_Q4 = 4'b0010,
    S_DELAY = 4'b0100,
    S_CONV = 4'b1000
  } adcpc_state_t;

  adcpc_pkg::adcpc_bus_t bus;
  adcpc_pkg::adcpc_pincfg_t cfg_nxt;
  adcpc_state_t state_r;
  logic [7:0] ctrl0_r;
  logic [7:0] ctrl1_r;
  logic [9:0] result_r;
  logic [1:0] phase_r;
  logic [3:0] tad_cnt_r;
  logic [2:0] dly_cnt_r;
  logic done_flag_r;
  logic complete;
  logic [7:0] res_hi;
  logic [7:0] res_lo;
  logic [7:0] port_in;

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // ----------------------------------------------------------------
  // port configuration decode
  // ----------------------------------------------------------------
  // table decode of the four-bit code; 011x both map to all digital
  always_comb begin
    cfg_nxt = '0;
    unique case (ctrl1_r[3:0])
      4'h0: cfg_nxt = '{8'hFF, 1'b0, 1'b0};
      4'h1: cfg_nxt = '{8'hF7, 1'b1, 1'b0};
      4'h2: cfg_nxt = '{8'h1F, 1'b0, 1'b0};
      4'h3: cfg_nxt = '{8'h17, 1'b1, 1'b0};
      4'h4: cfg_nxt = '{8'h0B, 1'b0, 1'b0};
      4'h5: cfg_nxt = '{8'h03, 1'b1, 1'b0};
      4'h6, 4'h7: cfg_nxt = '{8'h00, 1'b0, 1'b0};
      4'h8: cfg_nxt = '{8'hF3, 1'b1, 1'b1};
      4'h9: cfg_nxt = '{8'h3F, 1'b0, 1'b0};
      4'hA: cfg_nxt = '{8'h37, 1'b1, 1'b0};
      4'hB: cfg_nxt = '{8'h33, 1'b1, 1'b1};
      4'hC: cfg_nxt = '{8'h13, 1'b1, 1'b1};
      4'hD: cfg_nxt = '{8'h03, 1'b1, 1'b1};
      4'hE: cfg_nxt = '{8'h01, 1'b0, 1'b0};
      4'hF: cfg_nxt = '{8'h01, 1'b1, 1'b1};
    endcase
  end

  // registered pin routing so every output leaves a flip-flop
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_analog_sel <= 8'hFF;
      o_vref_pos_ext <= 1'b0;
      o_vref_neg_ext <= 1'b0;
      o_mux_ch <= 3'h0;
    end else begin
      o_analog_sel <= cfg_nxt.analog;
      o_vref_pos_ext <= cfg_nxt.vref_pos_ext;
      o_vref_neg_ext <= cfg_nxt.vref_neg_ext;
      o_mux_ch <= ctrl0_r[adcpc_pkg::CTRL0_CH_LO +: 3];
    end
  end

  // analog pins read as zero on the digital path
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_port
      assign port_in[g] = i_pin_level[g] & ~o_analog_sel[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // instruction phase: four osc periods per cycle
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phase_r <= 2'h0;
      o_instr_q4 <= 1'b0;
    end else if (i_osc_tick) begin
      phase_r <= phase_r + 2'h1;
      o_instr_q4 <= (phase_r == 2'(adcpc_pkg::OSC_PER_INSTR - 1));
    end else begin
      o_instr_q4 <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  // start is only armed by software once acquisition is done
  assign complete = (state_r == S_CONV) && i_tad_tick &&
                    (tad_cnt_r == 4'(CONV_CLKS - 1));

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= S_IDLE;
      tad_cnt_r <= 4'h0;
      dly_cnt_r <= 3'h0;
    end else begin
      unique case (state_r)
        S_IDLE: if (ctrl0_r[adcpc_pkg::CTRL0_START] &&
                    ctrl0_r[adcpc_pkg::CTRL0_ON]) begin
          state_r <= S_WAIT_Q4;
        end
        S_WAIT_Q4: if (o_instr_q4) begin
          // rc source adds a whole instruction so sleep can run
          dly_cnt_r <= ctrl0_r[adcpc_pkg::CTRL0_RC] ?
              3'(adcpc_pkg::TGO_HALF_OSC + adcpc_pkg::OSC_PER_INSTR) :
              3'(adcpc_pkg::TGO_HALF_OSC);
          state_r <= S_DELAY;
        end
        S_DELAY: if (i_osc_tick) begin
          if (dly_cnt_r <= 3'h1) begin
            tad_cnt_r <= 4'h0;
            state_r <= S_CONV;
          end else begin
            dly_cnt_r <= dly_cnt_r - 3'h1;
          end
        end
        S_CONV: if (complete) begin
          state_r <= S_IDLE;
        end else if (i_tad_tick) begin
          tad_cnt_r <= tad_cnt_r + 4'h1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // control registers, result and flag
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl0_r <= adcpc_pkg::RESET_BYTE;
      ctrl1_r <= adcpc_pkg::RESET_BYTE;
    end else begin
      if (bus.wr && bus.addr == adcpc_pkg::ADDR_CTRL1) begin
        ctrl1_r <= bus.wdata & adcpc_pkg::CTRL1_MASK;
      end
      if (bus.wr && bus.addr == adcpc_pkg::ADDR_CTRL0) begin
        ctrl0_r <= bus.wdata & adcpc_pkg::CTRL0_MASK;
      end
      if (complete) begin
        ctrl0_r[adcpc_pkg::CTRL0_START] <= 1'b0;
      end
    end
  end

  // flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      done_flag_r <= 1'b0;
      result_r <= 10'h000;
    end else begin
      if (complete) begin
        result_r <= i_sample;
        done_flag_r <= 1'b1;
      end else if (bus.wr && bus.addr == adcpc_pkg::ADDR_FLAG) begin
        done_flag_r <= bus.wdata[0];
      end
    end
  end

  assign res_hi = ctrl1_r[adcpc_pkg::CTRL1_JUSTIFY] ?
                  {6'h00, result_r[9:8]} : result_r[9:2];
  assign res_lo = ctrl1_r[adcpc_pkg::CTRL1_JUSTIFY] ?
                  result_r[7:0] : {result_r[1:0], 6'h00};

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
      o_done_flag <= 1'b0;
      o_sampling <= 1'b0;
    end else begin
      o_done_flag <= done_flag_r;
      o_sampling <= (state_r == S_IDLE) && ctrl0_r[adcpc_pkg::CTRL0_ON];
      o_rdata <= 8'h00;
      if (bus.rd) begin
        unique case (bus.addr)
          adcpc_pkg::ADDR_CTRL0: o_rdata <= ctrl0_r;
          adcpc_pkg::ADDR_CTRL1: o_rdata <= ctrl1_r;
          adcpc_pkg::ADDR_RES_HI: o_rdata <= res_hi;
          adcpc_pkg::ADDR_RES_LO: o_rdata <= res_lo;
          adcpc_pkg::ADDR_FLAG: o_rdata <= {7'h00, done_flag_r};
          adcpc_pkg::ADDR_PORT_IN: o_rdata <= port_in;
          default: o_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_done;
    complete ##1 done_flag_r;
  endsequence
  property p_done_event;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      complete |=> done_flag_r && !ctrl0_r[adcpc_pkg::CTRL0_START];
  endproperty
  a_done_event: assert property (p_done_event)
    else $error("done event did not clear start and set flag");
  property p_result_load;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      complete |=> result_r == $past(i_sample);
  endproperty
  a_result_load: assert property (p_result_load)
    else $error("result not loaded at completion");
  property p_right_just;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      ctrl1_r[adcpc_pkg::CTRL1_JUSTIFY] |-> res_hi[7:2] == 6'h00;
  endproperty
  a_right_just: assert property (p_right_just)
    else $error("right justified high bits not zero");
  property p_left_just;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      !ctrl1_r[adcpc_pkg::CTRL1_JUSTIFY] |-> res_lo[5:0] == 6'h00;
  endproperty
  a_left_just: assert property (p_left_just)
    else $error("left justified low bits not zero");
  property p_all_digital;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      ctrl1_r[3:1] == 3'b011 |=> o_analog_sel == 8'h00;
  endproperty
  a_all_digital: assert property (p_all_digital)
    else $error("codes 011x not all digital");
  property p_neg_ref;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      ctrl1_r[3:0] == 4'h8 |=> o_vref_neg_ext && o_vref_pos_ext;
  endproperty
  a_neg_ref: assert property (p_neg_ref)
    else $error("code 1000 must use both external references");
  property p_read_result;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      s_done ##0 (bus.rd && bus.addr == adcpc_pkg::ADDR_RES_LO)
      |=> o_rdata == res_lo;
  endproperty
  a_read_result: assert property (p_read_result)
    else $error("result not readable after completion");
  property p_q4_rate;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
      o_instr_q4 |=> !o_instr_q4;
  endproperty
  a_q4_rate: assert property (p_q4_rate)
    else $error("q4 marker longer than one cycle");
endmodule // adcpc_top

/* File: tb/adcpc_top_tb.sv */
/*
  adcpc_top_tb: register-level bench for the converter port configuration
  and conversion control block.
  assumes: design registers at the package offsets; reference pins are not
  counted as analog inputs; read data stand one cycle after the strobe.
*/
`timescale 1ns/10ps
module adcpc_top_tb;
  // ----------------------------------------------------------------
  // stimulus and design
  // ----------------------------------------------------------------
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_osc_tick = 1'b0;
  logic i_tad_tick = 1'b0;
  logic [7:0] i_pin_level = 8'hA5;
  logic [9:0] i_sample = 10'h2A5;
  logic [7:0] o_rdata, o_analog_sel;
  logic [2:0] o_mux_ch;
  logic o_vref_pos_ext, o_vref_neg_ext, o_sampling, o_done_flag, o_instr_q4;
  logic [1:0] tick_cnt = 2'h0;
  int n_errors = 0;
  int total_checks = 0;
  int t_plain, t_rc;
  // osc ticks come every second cycle, so one instruction is 8 cycles
  localparam int CYC_PER_INSTR = 2 * adcpc_pkg::OSC_PER_INSTR;
  localparam int ACQ_CYCLES = 40; // full acquisition, not the short one
  // analog masks for codes 0..15, references excluded
  logic [7:0] amask [16] = '{8'hFF, 8'hF7, 8'h1F, 8'h17, 8'h0B, 8'h03,
    8'h00, 8'h00, 8'hF3, 8'h3F, 8'h37, 8'h33, 8'h13, 8'h03, 8'h01, 8'h01};
  logic [15:0] pos_ext = 16'hBD2A;
  logic [15:0] neg_ext = 16'hB900;

  adcpc_top #(.CONV_CLKS(4)) i_adcpc_top (.i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .i_osc_tick(i_osc_tick), .i_tad_tick(i_tad_tick),
    .i_pin_level(i_pin_level), .i_sample(i_sample), .o_rdata(o_rdata),
    .o_analog_sel(o_analog_sel), .o_mux_ch(o_mux_ch),
    .o_vref_pos_ext(o_vref_pos_ext), .o_vref_neg_ext(o_vref_neg_ext),
    .o_sampling(o_sampling), .o_done_flag(o_done_flag),
    .o_instr_q4(o_instr_q4));

  initial begin
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  // oscillator and converter clock each tick every second cycle
  always @(posedge i_clk_sys) begin
    tick_cnt <= tick_cnt + 2'h1;
    i_osc_tick <= tick_cnt[0];
    i_tad_tick <= tick_cnt[0];
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  // read data land on the edge after the strobe; look just past it
  task automatic rd(input logic [2:0] a, input logic [7:0] exp,
                    input string what);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp, what);
  endtask
  // bounded wait for the next q4 marker; q counts the cycles to it
  task automatic wait_q4(output int q);
    q = 0;
    do begin
      @(posedge i_clk_sys);
      #1;
      q++;
      if (q > 100) begin
        n_errors++;
        $display("ERROR %0t q4 marker never seen", $time);
        end_sim();
      end
    end while (o_instr_q4 !== 1'b1);
  endtask
  // start a conversion and count cycles to the visible done flag;
  // the start is aligned to q4 so that two runs compare exactly
  task automatic convert(input logic [7:0] ctl, output int n);
    int q;
    wait_q4(q);
    wr(adcpc_pkg::ADDR_CTRL0, ctl);
    n = 0;
    while (o_done_flag !== 1'b1) begin
      @(posedge i_clk_sys);
      #1;
      n++;
      if (n > 2000) begin
        n_errors++;
        $display("ERROR %0t conversion never completed", $time);
        end_sim();
      end
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int q;
    repeat (12) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    #1;
    chk(o_analog_sel, 8'hFF, "reset analog select");
    rd(adcpc_pkg::ADDR_CTRL1, 8'h00, "reset ctrl1");
    rd(3'h6, 8'h00, "unmapped read");
    $display("test reset done");
    // every configuration code, incl. both 011x forms
    for (int c = 0; c < 16; c++) begin
      wr(adcpc_pkg::ADDR_CTRL1, {4'h0, c[3:0]});
      @(posedge i_clk_sys); // pin routing is registered once more
      #1;
      chk(o_analog_sel, amask[c], "analog select");
      chk({7'h0, o_vref_pos_ext}, {7'h0, pos_ext[c]}, "pos ref");
      chk({7'h0, o_vref_neg_ext}, {7'h0, neg_ext[c]}, "neg ref");
      rd(adcpc_pkg::ADDR_PORT_IN, i_pin_level & ~amask[c], "port");
    end
    wr(adcpc_pkg::ADDR_CTRL1, 8'hFF);
    rd(adcpc_pkg::ADDR_CTRL1, 8'h8F, "ctrl1 unused bits");
    $display("test port config done");
    // instruction phase: four oscillator periods of two cycles each
    wait_q4(q);
    wait_q4(q);
    chk(q[7:0], 8'(CYC_PER_INSTR), "q4 spacing");
    // channel 5 made an analog input first, enabled and idle: acquiring
    wr(adcpc_pkg::ADDR_CTRL1, 8'h80);
    wr(adcpc_pkg::ADDR_CTRL0, 8'h29);
    @(posedge i_clk_sys);
    #1;
    chk({5'h0, o_mux_ch}, 8'h05, "channel");
    chk({7'h0, o_sampling}, 8'h01, "sampling");
    repeat (ACQ_CYCLES) @(posedge i_clk_sys);
    convert(8'h2D, t_plain);
    rd(adcpc_pkg::ADDR_FLAG, 8'h01, "done flag");
    rd(adcpc_pkg::ADDR_CTRL0, 8'h29, "start cleared");
    rd(adcpc_pkg::ADDR_RES_HI, 8'h02, "right high");
    rd(adcpc_pkg::ADDR_RES_LO, 8'hA5, "right low");
    wr(adcpc_pkg::ADDR_CTRL1, 8'h0F);
    rd(adcpc_pkg::ADDR_RES_HI, 8'hA9, "left high");
    rd(adcpc_pkg::ADDR_RES_LO, 8'h40, "left low");
    wr(adcpc_pkg::ADDR_FLAG, 8'h00);
    rd(adcpc_pkg::ADDR_FLAG, 8'h00, "flag cleared");
    chk({7'h0, t_plain >= 8}, 8'h01, "conversion length");
    $display("test conversion done");
    // rc source inserts an extra instruction cycle before the clock
    @(posedge i_clk_sys);
    i_sample <= 10'h3C1;
    repeat (ACQ_CYCLES) @(posedge i_clk_sys);
    convert(8'h45, t_rc);
    chk(8'(t_rc - t_plain), 8'(CYC_PER_INSTR), "rc start delay");
    wr(adcpc_pkg::ADDR_CTRL1, 8'h80);
    rd(adcpc_pkg::ADDR_RES_HI, 8'h03, "second high");
    rd(adcpc_pkg::ADDR_RES_LO, 8'hC1, "second low");
    $display("test rc conversion done");
    end_sim();
  end
endmodule // adcpc_top_tb
